// ### rtl/csi_debounce.sv
// Synchroniser and debounce filter for one input level
module csi_debounce #(
  parameter int STABLE_CYC = 100000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic raw,
  input wire logic init,
  output logic clean
);
  logic sync1;
  logic sync2;
  logic [19:0] cnt;

  // Two-flop synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // Output changes only after the new level holds for the full window, except that init clears it at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 20'h00000;
      clean <= 1'b0;
    end else if (init) begin
      cnt <= 20'h00000;
      clean <= 1'b0;
    end else if (sync2 == clean) begin
      cnt <= 20'h00000;
    end else if (cnt >= 20'(STABLE_CYC - 1)) begin
      cnt <= 20'h00000;
      clean <= sync2;
    end else begin
      cnt <= cnt + 20'h00001;
    end
  end
endmodule : csi_debounce

// ### rtl/csi_interlock.sv
// Crane safety interlock, valve ramp control and diagnostic register slave
//
// Added by the designer: the APB interface to the registers and the register offsets.
module csi_interlock #(
  parameter int DEBOUNCE_CYC = csi_pkg::CSI_DEBOUNCE_CYC,
  parameter int TICK_CYC = csi_pkg::CSI_TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hoist_block_limit_input,
  input wire logic overload_switch_in,
  input wire logic [15:0] sensor_mv,
  input wire logic [7:0] cmd_motion,
  output logic [7:0] motion_out,
  output logic pump_out,
  output logic [15:0] valve_ma,
  output logic [15:0] dither_hz,
  output logic overload_flag,
  output logic irq
);
  // Motion bit order: 0 hoist up, 1 hoist down, 2 extend out, 3 extend in,
  // 4 boom up, 5 boom down, 6 rotate cw, 7 rotate ccw
  localparam int HU = 0;
  localparam int HD = 1;
  localparam int EO = 2;
  localparam int BD = 5;

  typedef enum logic [1:0] {
    CSI_IDLE = 2'b00,
    CSI_UP = 2'b01,
    CSI_RUN = 2'b10,
    CSI_DOWN = 2'b11
  } csi_ramp_t;

  localparam int CSI_NERR_W = csi_pkg::CSI_NERR;
  logic [3:0] ctrl;
  logic [15:0] min_ma, max_ma, ramp_up, ramp_dn, dither, max_psi, overload_threshold, min_mv, max_mv;
  logic [3:0] sv_ctrl;
  logic [15:0] sv_min_ma, sv_max_ma, sv_ramp_up, sv_ramp_dn, sv_dither;
  logic [15:0] sv_max_psi, sv_overload_threshold, sv_min_mv, sv_max_mv;
  logic limit_ok, ovl_sw_ok;
  logic [15:0] psi;
  logic ovl_sens, ovl_now, ovl_prev, limit_bad, limit_prev;
  logic [7:0] allow, gated;
  logic [15:0] ovl_cnt;
  logic [CSI_NERR_W-1:0] err_act;
  logic [15:0] err_cnt [csi_pkg::CSI_NERR];
  logic [CSI_NERR_W-1:0] err_prev, irq_stat, irq_en;
  logic wr, rd;
  logic [3:0] cmd;
  logic [31:0] tick_cnt;
  logic tick;
  csi_ramp_t ramp_st;
  logic [31:0] ramp_acc;
  logic cfg_dirty;

  // Write-one command pulses
  function automatic logic cmd_bit(input logic [31:0] d, input int b);
    return d[b];
  endfunction : cmd_bit

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign cmd = (wr && paddr == csi_pkg::CSI_REG_CMD) ? pwdata[3:0] : 4'h0;

  // Addresses above the IRQ clear register and outside the error counter block answer with an error
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable && paddr > csi_pkg::CSI_REG_IRQ_CLR &&
        (paddr < csi_pkg::CSI_REG_ERR_CNT0 ||
         paddr >= csi_pkg::CSI_REG_ERR_CNT0 + 8'(4 * csi_pkg::CSI_NERR)))
      pslverr = 1'b1;
  end

  // Live configuration: writes, and reload of factory defaults by command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= csi_pkg::CSI_CTRL_RST;
      min_ma <= csi_pkg::CSI_MIN_MA_RST;
      max_ma <= csi_pkg::CSI_MAX_MA_RST;
      ramp_up <= csi_pkg::CSI_RAMP_RST;
      ramp_dn <= csi_pkg::CSI_RAMP_RST;
      dither <= csi_pkg::CSI_DITHER_RST;
      max_psi <= csi_pkg::CSI_MAX_PSI_RST;
      overload_threshold <= csi_pkg::CSI_OVERLOAD_THRESHOLD_RST;
      min_mv <= csi_pkg::CSI_MIN_MV_RST;
      max_mv <= csi_pkg::CSI_MAX_MV_RST;
    end else if (cmd_bit({28'h0, cmd}, csi_pkg::CSI_CMD_DEFAULTS)) begin
      ctrl <= csi_pkg::CSI_CTRL_RST;
      min_ma <= csi_pkg::CSI_MIN_MA_RST;
      max_ma <= csi_pkg::CSI_MAX_MA_RST;
      ramp_up <= csi_pkg::CSI_RAMP_RST;
      ramp_dn <= csi_pkg::CSI_RAMP_RST;
      dither <= csi_pkg::CSI_DITHER_RST;
      max_psi <= csi_pkg::CSI_MAX_PSI_RST;
      overload_threshold <= csi_pkg::CSI_OVERLOAD_THRESHOLD_RST;
      min_mv <= csi_pkg::CSI_MIN_MV_RST;
      max_mv <= csi_pkg::CSI_MAX_MV_RST;
    end else if (wr) begin
      unique case (paddr)
        csi_pkg::CSI_REG_CTRL: ctrl <= pwdata[3:0];
        csi_pkg::CSI_REG_MIN_MA: min_ma <= pwdata[15:0];
        csi_pkg::CSI_REG_MAX_MA: max_ma <= pwdata[15:0];
        csi_pkg::CSI_REG_RAMP_UP: ramp_up <= pwdata[15:0];
        csi_pkg::CSI_REG_RAMP_DN: ramp_dn <= pwdata[15:0];
        csi_pkg::CSI_REG_DITHER: dither <= pwdata[15:0];
        csi_pkg::CSI_REG_MAX_PSI: max_psi <= pwdata[15:0];
        csi_pkg::CSI_REG_OVERLOAD_THRESHOLD: overload_threshold <= pwdata[15:0];
        csi_pkg::CSI_REG_MIN_MV: min_mv <= pwdata[15:0];
        csi_pkg::CSI_REG_MAX_MV: max_mv <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Retained copy updated only by the save command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sv_ctrl <= csi_pkg::CSI_CTRL_RST;
      sv_min_ma <= csi_pkg::CSI_MIN_MA_RST;
      sv_max_ma <= csi_pkg::CSI_MAX_MA_RST;
      sv_ramp_up <= csi_pkg::CSI_RAMP_RST;
      sv_ramp_dn <= csi_pkg::CSI_RAMP_RST;
      sv_dither <= csi_pkg::CSI_DITHER_RST;
      sv_max_psi <= csi_pkg::CSI_MAX_PSI_RST;
      sv_overload_threshold <= csi_pkg::CSI_OVERLOAD_THRESHOLD_RST;
      sv_min_mv <= csi_pkg::CSI_MIN_MV_RST;
      sv_max_mv <= csi_pkg::CSI_MAX_MV_RST;
    end else if (cmd[csi_pkg::CSI_CMD_SAVE]) begin
      sv_ctrl <= ctrl;
      sv_min_ma <= min_ma;
      sv_max_ma <= max_ma;
      sv_ramp_up <= ramp_up;
      sv_ramp_dn <= ramp_dn;
      sv_dither <= dither;
      sv_max_psi <= max_psi;
      sv_overload_threshold <= overload_threshold;
      sv_min_mv <= min_mv;
      sv_max_mv <= max_mv;
    end
  end

  // Live settings differ from the retained copy, so a save is still pending
  assign cfg_dirty = {ctrl, min_ma, max_ma, ramp_up, ramp_dn, dither, max_psi, overload_threshold, min_mv,
                      max_mv} != {sv_ctrl, sv_min_ma, sv_max_ma, sv_ramp_up, sv_ramp_dn,
                      sv_dither, sv_max_psi, sv_overload_threshold, sv_min_mv, sv_max_mv};

  // Filtered safety inputs
  csi_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_limit (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(hoist_block_limit_input),
    .init(1'b0),
    .clean(limit_ok)
  );
  csi_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_ovl (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(overload_switch_in),
    .init(1'b0),
    .clean(ovl_sw_ok)
  );

  // Linear voltage to pressure conversion, clamped at both ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psi <= 16'h0000;
    end else if (sensor_mv <= min_mv || max_mv <= min_mv) begin
      psi <= 16'h0000;
    end else if (sensor_mv >= max_mv) begin
      psi <= max_psi;
    end else begin
      psi <= 16'((32'(sensor_mv - min_mv) * 32'(max_psi)) / 32'(max_mv - min_mv));
    end
  end

  // Overload source: sensor mode excludes switch mode
  assign ovl_sens = ctrl[csi_pkg::CSI_CTRL_SENSOR] && (psi >= overload_threshold);
  assign ovl_now = ctrl[csi_pkg::CSI_CTRL_SENSOR] ? ovl_sens : !ovl_sw_ok;
  assign limit_bad = !limit_ok;

  // Allowed motions from limit and overload state
  always_comb begin
    allow = 8'hFF;
    if (limit_bad) begin
      allow[HU] = 1'b0;
      allow[EO] = 1'b0;
      if (!ctrl[csi_pkg::CSI_CTRL_OVERRIDE])
        allow[BD] = 1'b0;
    end
    if (ovl_now) begin
      allow[HU] = 1'b0;
      allow[EO] = 1'b0;
      allow[BD] = 1'b0;
    end
  end
  assign gated = cmd_motion & allow;

  // Registered motion, pump and flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      motion_out <= 8'h00;
      pump_out <= 1'b0;
      overload_flag <= 1'b0;
      dither_hz <= csi_pkg::CSI_DITHER_RST;
    end else begin
      motion_out <= gated;
      pump_out <= ctrl[csi_pkg::CSI_CTRL_PUMP] && (gated[HU] || gated[HD]);
      overload_flag <= ovl_now;
      dither_hz <= dither;
    end
  end

  // Millisecond tick for ramps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYC - 1)) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // Valve current ramp: accumulator in milliamp-milliseconds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_st <= CSI_IDLE;
      ramp_acc <= 32'h00000000;
      valve_ma <= 16'h0000;
    end else if (ctrl[csi_pkg::CSI_CTRL_SWITCHED]) begin
      ramp_st <= CSI_IDLE;
      ramp_acc <= 32'h00000000;
      valve_ma <= (|gated) ? 16'hFFFF : 16'h0000;
    end else begin
      unique case (ramp_st)
        CSI_IDLE: begin
          valve_ma <= 16'h0000;
          ramp_acc <= 32'h00000000;
          if (|gated) begin
            ramp_st <= CSI_UP;
            valve_ma <= min_ma;
          end
        end
        CSI_UP: begin
          if (!(|gated)) begin
            ramp_st <= CSI_DOWN;
            ramp_acc <= 32'h00000000;
          end else if (valve_ma >= max_ma) begin
            ramp_st <= CSI_RUN;
            valve_ma <= max_ma;
          end else if (tick) begin
            ramp_acc <= ramp_acc + 32'(max_ma - min_ma);
            valve_ma <= 16'(32'(min_ma) + (ramp_acc + 32'(max_ma - min_ma)) /
                            (32'(ramp_up) * 32'(csi_pkg::CSI_TICK_HZ) + 32'h1));
          end
        end
        CSI_RUN: begin
          valve_ma <= max_ma;
          if (!(|gated)) begin
            ramp_st <= CSI_DOWN;
            ramp_acc <= 32'h00000000;
          end
        end
        CSI_DOWN: begin
          if (|gated) begin
            ramp_st <= CSI_UP;
            ramp_acc <= 32'h00000000;
            valve_ma <= min_ma;
          end else if (valve_ma == 16'h0000) begin
            ramp_st <= CSI_IDLE;
          end else if (tick) begin
            ramp_acc <= ramp_acc + 32'(max_ma);
            if ((ramp_acc + 32'(max_ma)) / (32'(ramp_dn) * 32'(csi_pkg::CSI_TICK_HZ) + 32'h1)
                >= 32'(max_ma))
              valve_ma <= 16'h0000;
            else
              valve_ma <= max_ma - 16'((ramp_acc + 32'(max_ma)) /
                          (32'(ramp_dn) * 32'(csi_pkg::CSI_TICK_HZ) + 32'h1));
          end
        end
      endcase
    end
  end

  // Overload occurrence counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovl_prev <= 1'b1; // Filters start tripped; that power-up state is no occurrence
      ovl_cnt <= 16'h0000;
    end else begin
      ovl_prev <= ovl_now;
      if (ovl_now && !ovl_prev && ovl_cnt != 16'hFFFF)
        ovl_cnt <= ovl_cnt + 16'h0001;
      else if (cmd[csi_pkg::CSI_CMD_OVL_RST])
        ovl_cnt <= 16'h0000;
    end
  end

  // Error code active flags
  assign err_act[csi_pkg::CSI_ERR_OVL] = ovl_now;
  assign err_act[csi_pkg::CSI_ERR_LIMIT] = limit_bad;
  assign err_act[csi_pkg::CSI_ERR_OVL_SENS] = ovl_sens;
  assign err_act[csi_pkg::CSI_ERR_CLAMP] = |(cmd_motion & ~allow);

  // Per-code occurrence counters; a new occurrence wins over reset
  genvar gi;
  generate
    for (gi = 0; gi < csi_pkg::CSI_NERR; gi++) begin : g_err
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          err_cnt[gi] <= 16'h0000;
        end else if (err_act[gi] && !err_prev[gi] && err_cnt[gi] != 16'hFFFF) begin
          err_cnt[gi] <= err_cnt[gi] + 16'h0001;
        end else if (cmd[csi_pkg::CSI_CMD_ERR_RST]) begin
          err_cnt[gi] <= 16'h0000;
        end
      end
    end
  endgenerate

  // Sticky interrupt status on error rise; set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_prev <= '1; // No false error edge while the filters settle after reset
      irq_stat <= '0;
      irq_en <= '0;
      irq <= 1'b0;
    end else begin
      err_prev <= err_act;
      irq_stat <= (irq_stat & ~((wr && paddr == csi_pkg::CSI_REG_IRQ_CLR) ?
                   pwdata[CSI_NERR_W-1:0] : '0)) | (err_act & ~err_prev);
      if (wr && paddr == csi_pkg::CSI_REG_IRQ_EN)
        irq_en <= pwdata[CSI_NERR_W-1:0];
      irq <= |(irq_stat & irq_en);
    end
  end

  // Read data register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      unique case (paddr)
        csi_pkg::CSI_REG_CTRL: prdata <= {28'h0, ctrl};
        csi_pkg::CSI_REG_CMD: prdata <= {31'h0, cfg_dirty};
        csi_pkg::CSI_REG_MIN_MA: prdata <= {16'h0, min_ma};
        csi_pkg::CSI_REG_MAX_MA: prdata <= {16'h0, max_ma};
        csi_pkg::CSI_REG_RAMP_UP: prdata <= {16'h0, ramp_up};
        csi_pkg::CSI_REG_RAMP_DN: prdata <= {16'h0, ramp_dn};
        csi_pkg::CSI_REG_DITHER: prdata <= {16'h0, dither};
        csi_pkg::CSI_REG_MAX_PSI: prdata <= {16'h0, max_psi};
        csi_pkg::CSI_REG_OVERLOAD_THRESHOLD: prdata <= {16'h0, overload_threshold};
        csi_pkg::CSI_REG_MIN_MV: prdata <= {16'h0, min_mv};
        csi_pkg::CSI_REG_MAX_MV: prdata <= {16'h0, max_mv};
        csi_pkg::CSI_REG_IO: prdata <= {12'h0, overload_flag, pump_out, motion_out,
                                        cmd_motion, ovl_sw_ok, limit_ok};
        csi_pkg::CSI_REG_PSI: prdata <= {16'h0, psi};
        csi_pkg::CSI_REG_OVL_CNT: prdata <= {16'h0, ovl_cnt};
        csi_pkg::CSI_REG_ERR_ACT: prdata <= {28'h0, err_act};
        csi_pkg::CSI_REG_IRQ_STAT: prdata <= {28'h0, irq_stat};
        csi_pkg::CSI_REG_IRQ_EN: prdata <= {28'h0, irq_en};
        csi_pkg::CSI_REG_ERR_CNT0: prdata <= {16'h0, err_cnt[0]};
        csi_pkg::CSI_REG_ERR_CNT0 + 8'h04: prdata <= {16'h0, err_cnt[1]};
        csi_pkg::CSI_REG_ERR_CNT0 + 8'h08: prdata <= {16'h0, err_cnt[2]};
        csi_pkg::CSI_REG_ERR_CNT0 + 8'h0C: prdata <= {16'h0, err_cnt[3]};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule : csi_interlock

// ### shared/csi_pkg.sv
// Package of register map, field layouts, defaults and timing constants
package csi_pkg;
  // Register byte offsets
  localparam logic [7:0] CSI_REG_CTRL = 8'h00;
  localparam logic [7:0] CSI_REG_CMD = 8'h04;
  localparam logic [7:0] CSI_REG_MIN_MA = 8'h08;
  localparam logic [7:0] CSI_REG_MAX_MA = 8'h0C;
  localparam logic [7:0] CSI_REG_RAMP_UP = 8'h10;
  localparam logic [7:0] CSI_REG_RAMP_DN = 8'h14;
  localparam logic [7:0] CSI_REG_DITHER = 8'h18;
  localparam logic [7:0] CSI_REG_MAX_PSI = 8'h1C;
  localparam logic [7:0] CSI_REG_OVERLOAD_THRESHOLD = 8'h20;
  localparam logic [7:0] CSI_REG_MIN_MV = 8'h24;
  localparam logic [7:0] CSI_REG_MAX_MV = 8'h28;
  localparam logic [7:0] CSI_REG_IO = 8'h2C;
  localparam logic [7:0] CSI_REG_PSI = 8'h30;
  localparam logic [7:0] CSI_REG_OVL_CNT = 8'h34;
  localparam logic [7:0] CSI_REG_ERR_ACT = 8'h38;
  localparam logic [7:0] CSI_REG_IRQ_STAT = 8'h3C;
  localparam logic [7:0] CSI_REG_IRQ_EN = 8'h40;
  localparam logic [7:0] CSI_REG_IRQ_CLR = 8'h44;
  localparam logic [7:0] CSI_REG_ERR_CNT0 = 8'h80;
  // CTRL fields
  localparam int CSI_CTRL_OVERRIDE = 0;
  localparam int CSI_CTRL_SENSOR = 1;
  localparam int CSI_CTRL_PUMP = 2;
  localparam int CSI_CTRL_SWITCHED = 3;
  // CMD fields (write-one pulses)
  localparam int CSI_CMD_SAVE = 0;
  localparam int CSI_CMD_DEFAULTS = 1;
  localparam int CSI_CMD_OVL_RST = 2;
  localparam int CSI_CMD_ERR_RST = 3;
  // Error code slots
  localparam int CSI_NERR = 4;
  localparam int CSI_ERR_OVL = 0;
  localparam int CSI_ERR_LIMIT = 1;
  localparam int CSI_ERR_OVL_SENS = 2;
  localparam int CSI_ERR_CLAMP = 3;
  // Factory defaults
  localparam logic [3:0] CSI_CTRL_RST = 4'h0;
  localparam logic [15:0] CSI_MIN_MA_RST = 16'h00C8;
  localparam logic [15:0] CSI_MAX_MA_RST = 16'h03E8;
  localparam logic [15:0] CSI_RAMP_RST = 16'h0001;
  localparam logic [15:0] CSI_DITHER_RST = 16'h00C8;
  localparam logic [15:0] CSI_MAX_PSI_RST = 16'h1388;
  localparam logic [15:0] CSI_OVERLOAD_THRESHOLD_RST = 16'h0BB8;
  localparam logic [15:0] CSI_MIN_MV_RST = 16'h0370;
  localparam logic [15:0] CSI_MAX_MV_RST = 16'h1130;
  // Timing
  localparam int CSI_CLK_HZ = 100000000;
  localparam int CSI_DEBOUNCE_US = 1000;
  localparam int CSI_DEBOUNCE_CYC = CSI_DEBOUNCE_US * (CSI_CLK_HZ / 1000000);
  localparam int CSI_TICK_HZ = 1000;
  localparam int CSI_TICK_CYC = CSI_CLK_HZ / CSI_TICK_HZ;
endpackage : csi_pkg

// ### sim/csi_field_model.sv
// Field side model: limit switch, overload switch and pressure sensor
module csi_field_model #(
  parameter int MIN_MV = 880,
  parameter int MAX_MV = 4400,
  parameter int FULL_PSI = 5000
) (
  input wire logic lim_ok,
  input wire logic sw_ok,
  input wire logic [15:0] psi,
  output logic hoist_block_limit_input,
  output logic overload_switch_in,
  output logic [15:0] sensor_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  // Switches close when healthy; sensor voltage is linear in pressure
  assign hoist_block_limit_input = lim_ok;
  assign overload_switch_in = sw_ok;
  assign sensor_mv = 16'(MIN_MV + (int'(psi) * (MAX_MV - MIN_MV)) / FULL_PSI);
endmodule : csi_field_model

// ### sim/csi_interlock_assertions.sv
// Port-level checker for interlock gating, pump, valve and dither behaviour
module csi_interlock_assertions #(
  parameter int DEBOUNCE_CYC = 4,
  parameter int TICK_CYC = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic hoist_block_limit_input,
  input wire logic overload_switch_in,
  input wire logic [7:0] cmd_motion,
  input wire logic [7:0] motion_out,
  input wire logic pump_out,
  input wire logic [15:0] valve_ma,
  input wire logic [15:0] dither_hz,
  input wire logic overload_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sync, filter and output register all fit inside this margin
  localparam int SETTLE = DEBOUNCE_CYC + 6;
  logic [3:0] ctl;
  int lim_lo;
  int sw_lo;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Shadow of the control register, taken from completed writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 4'h0;
    end else if (psel && penable && pwrite && paddr == csi_pkg::CSI_REG_CMD &&
                 pwdata[csi_pkg::CSI_CMD_DEFAULTS]) begin
      ctl <= csi_pkg::CSI_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == csi_pkg::CSI_REG_CTRL) begin
      ctl <= pwdata[3:0];
    end
  end
  // Saturating counts of how long each safety input has been low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lim_lo <= 0;
      sw_lo <= 0;
    end else begin
      lim_lo <= hoist_block_limit_input ? 0 : (lim_lo < SETTLE ? lim_lo + 1 : lim_lo);
      sw_lo <= overload_switch_in ? 0 : (sw_lo < SETTLE ? sw_lo + 1 : sw_lo);
    end
  end
  a_limit_hoist_ext: assert property (lim_lo >= SETTLE |-> (motion_out & 8'h05) == 8'h00)
    else $error("hoist-up or extend-out active with limit tripped");
  a_limit_boom_dn: assert property (lim_lo >= SETTLE && !ctl[0] && !$past(ctl[0]) |-> !motion_out[5])
    else $error("boom-down active with limit tripped and override off");
  a_switch_ovl: assert property (sw_lo >= SETTLE && !ctl[1] && !$past(ctl[1]) |-> (motion_out & 8'h25) == 8'h00)
    else $error("motion active with overload switch tripped");
  a_flag_blocks: assert property (overload_flag && $past(overload_flag) |-> (motion_out & 8'h25) == 8'h00)
    else $error("motion active while overload flagged");
  a_cmd_only: assert property ((motion_out & ~$past(cmd_motion)) == 8'h00)
    else $error("output on without a command");
  a_pump_hoist: assert property (pump_out == ($past(ctl[2]) && (motion_out[0] || motion_out[1])))
    else $error("pump output does not follow hoist");
  a_switched_full: assert property (ctl[3] && $past(ctl[3]) && $past(ctl[3], 2) |-> valve_ma == 16'h0000 || valve_ma == 16'hFFFF)
    else $error("valve current partial in switched mode");
  a_dither_copy: assert property (psel && penable && pwrite && paddr == csi_pkg::CSI_REG_DITHER |-> ##2 dither_hz == $past(pwdata[15:0], 2))
    else $error("dither output did not take written value");
endmodule : csi_interlock_assertions

bind csi_interlock csi_interlock_assertions #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .TICK_CYC(TICK_CYC))
  u_chk (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .hoist_block_limit_input,
  .overload_switch_in, .cmd_motion, .motion_out, .pump_out, .valve_ma, .dither_hz, .overload_flag);

// ### sim/csi_interlock_bench.sv
// Self-checking bench for the crane safety interlock block
module csi_interlock_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEB = 4;
  localparam int TICK = 10;
  localparam int SET = DEB + 8;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, lim_ok, sw_ok;
  logic hoist_block_limit_input, overload_switch_in, pump_out, overload_flag, irq;
  logic [7:0] paddr, cmd_motion, motion_out;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] psi, sensor_mv, valve_ma, dither_hz;
  int n_fail;
  int check_count;
  csi_interlock #(.DEBOUNCE_CYC(DEB), .TICK_CYC(TICK)) dut (.mclk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hoist_block_limit_input,
    .overload_switch_in, .sensor_mv, .cmd_motion, .motion_out, .pump_out, .valve_ma,
    .dither_hz, .overload_flag, .irq);
  csi_field_model u_field (.lim_ok, .sw_ok, .psi, .hoist_block_limit_input,
    .overload_switch_in, .sensor_mv);
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  // One APB transfer; waits for pready, then releases the bus
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(exp, rd);
  endtask : rdc
  task automatic setin(input logic l, input logic s, input logic [15:0] p, input logic [7:0] c);
    @(posedge mclk);
    lim_ok <= l;
    sw_ok <= s;
    psi <= p;
    cmd_motion <= c;
  endtask : setin
  task automatic nw(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : nw
  task automatic t_regs();
    rdc(csi_pkg::CSI_REG_CTRL, 32'h0);
    rdc(csi_pkg::CSI_REG_OVL_CNT, 32'h0);
    rdc(csi_pkg::CSI_REG_OVERLOAD_THRESHOLD, 32'h0BB8);
    rdc(csi_pkg::CSI_REG_MAX_PSI, 32'h1388);
    rdc(csi_pkg::CSI_REG_MIN_MV, 32'h0370);
    rdc(csi_pkg::CSI_REG_MAX_MV, 32'h1130);
    apb(1'b0, 8'h48, 32'h0);
    chk(32'h1, 32'(err));
    chk(32'h0, rd);
    wr(csi_pkg::CSI_REG_DITHER, 32'h0064);
    nw(2);
    chk(32'h0064, 32'(dither_hz));
    $display("t_regs done");
  endtask : t_regs
  task automatic t_limit();
    setin(1'b0, 1'b1, 16'h0, 8'hFF);
    nw(SET);
    chk(32'hDA, 32'(motion_out));
    wr(csi_pkg::CSI_REG_CTRL, 32'h1);
    nw(2);
    chk(32'hFA, 32'(motion_out));
    setin(1'b0, 1'b1, 16'h0, 8'h18);
    nw(2);
    chk(32'h18, 32'(motion_out));
    setin(1'b1, 1'b1, 16'h0, 8'hFF);
    wr(csi_pkg::CSI_REG_CTRL, 32'h0);
    nw(SET);
    setin(1'b0, 1'b1, 16'h0, 8'hFF);
    setin(1'b1, 1'b1, 16'h0, 8'hFF);
    repeat (SET) begin
      @(negedge mclk);
      chk(32'hFF, 32'(motion_out));
    end
    $display("t_limit done");
  endtask : t_limit
  task automatic t_switch();
    setin(1'b1, 1'b0, 16'h0, 8'hFF);
    nw(SET);
    chk(32'hDA, 32'(motion_out));
    wr(csi_pkg::CSI_REG_CTRL, 32'h2);
    nw(SET);
    chk(32'hFF, 32'(motion_out));
    $display("t_switch done");
  endtask : t_switch
  task automatic t_sensor();
    logic [31:0] c;
    logic [31:0] s;
    setin(1'b1, 1'b0, 16'd2500, 8'hFF);
    nw(3);
    rdc(csi_pkg::CSI_REG_PSI, 32'd2500);
    apb(1'b0, csi_pkg::CSI_REG_OVL_CNT, 32'h0);
    c = rd;
    wr(csi_pkg::CSI_REG_IRQ_EN, 32'h0);
    wr(csi_pkg::CSI_REG_IRQ_CLR, 32'hFFFF_FFFF);
    setin(1'b1, 1'b0, 16'd3000, 8'hFF);
    nw(3);
    chk(32'h1, 32'(overload_flag));
    chk(32'hDA, 32'(motion_out));
    chk(32'h0, 32'(irq));
    apb(1'b0, csi_pkg::CSI_REG_ERR_ACT, 32'h0);
    chk(32'h1, 32'(rd[csi_pkg::CSI_ERR_OVL]));
    rdc(csi_pkg::CSI_REG_IRQ_STAT, 32'((1 << csi_pkg::CSI_ERR_OVL) |
        (1 << csi_pkg::CSI_ERR_OVL_SENS) | (1 << csi_pkg::CSI_ERR_CLAMP)));
    s = rd;
    wr(csi_pkg::CSI_REG_IRQ_EN, s);
    nw(2);
    chk(32'h1, 32'(irq));
    setin(1'b1, 1'b0, 16'd2999, 8'hFF);
    nw(3);
    chk(32'hFF, 32'(motion_out));
    rdc(csi_pkg::CSI_REG_OVL_CNT, c + 32'h1);
    wr(csi_pkg::CSI_REG_IRQ_CLR, s);
    nw(2);
    chk(32'h0, 32'(irq));
    wr(csi_pkg::CSI_REG_CMD, 32'hC);
    rdc(csi_pkg::CSI_REG_OVL_CNT, 32'h0);
    rdc(csi_pkg::CSI_REG_ERR_CNT0, 32'h0);
    setin(1'b1, 1'b1, 16'h0, 8'h00);
    wr(csi_pkg::CSI_REG_CTRL, 32'h0);
    $display("t_sensor done");
  endtask : t_sensor
  task automatic t_valve();
    setin(1'b1, 1'b1, 16'h0, 8'h02);
    nw(3);
    chk(32'h1, 32'(valve_ma >= 16'd200 && valve_ma <= 16'd210));
    nw(TICK * 500);
    chk(32'h1, 32'(valve_ma > 16'd560 && valve_ma < 16'd640));
    nw(TICK * 500 + 20);
    chk(32'd1000, 32'(valve_ma));
    setin(1'b1, 1'b1, 16'h0, 8'h00);
    nw(TICK * 500);
    chk(32'h1, 32'(valve_ma > 16'd450 && valve_ma < 16'd550));
    nw(TICK * 500 + 20);
    chk(32'h0, 32'(valve_ma));
    wr(csi_pkg::CSI_REG_CTRL, 32'h8);
    setin(1'b1, 1'b1, 16'h0, 8'h02);
    nw(4);
    chk(32'hFFFF, 32'(valve_ma));
    setin(1'b1, 1'b1, 16'h0, 8'h00);
    nw(4);
    chk(32'h0, 32'(valve_ma));
    wr(csi_pkg::CSI_REG_CTRL, 32'h4);
    setin(1'b1, 1'b1, 16'h0, 8'h01);
    nw(3);
    chk(32'h1, 32'(pump_out));
    setin(1'b1, 1'b1, 16'h0, 8'h10);
    nw(3);
    chk(32'h0, 32'(pump_out));
    $display("t_valve done");
  endtask : t_valve
  task automatic t_misc();
    wr(csi_pkg::CSI_REG_CTRL, 32'h0);
    setin(1'b1, 1'b1, 16'h0, 8'h5A);
    nw(SET);
    apb(1'b0, csi_pkg::CSI_REG_IO, 32'h0);
    chk(32'h3 | (32'h5A << 2) | (32'h5A << 10), rd);
    wr(csi_pkg::CSI_REG_MIN_MA, 32'h0064);
    rdc(csi_pkg::CSI_REG_MIN_MA, 32'h0064);
    rdc(csi_pkg::CSI_REG_CMD, 32'h1);
    wr(csi_pkg::CSI_REG_CMD, 32'h2);
    rdc(csi_pkg::CSI_REG_MIN_MA, 32'h00C8);
    rdc(csi_pkg::CSI_REG_MAX_MA, 32'h03E8);
    nw(2);
    chk(32'h00C8, 32'(dither_hz));
    rdc(csi_pkg::CSI_REG_CMD, 32'h0);
    wr(csi_pkg::CSI_REG_MIN_MA, 32'h0064);
    wr(csi_pkg::CSI_REG_CMD, 32'h1);
    rdc(csi_pkg::CSI_REG_CMD, 32'h0);
    wr(csi_pkg::CSI_REG_CMD, 32'h2);
    rdc(csi_pkg::CSI_REG_CMD, 32'h1);
    $display("t_misc done");
  endtask : t_misc
  task automatic end_sim();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // Watchdog against a hung handshake
  initial begin
    #600us;
    n_fail++;
    end_sim();
  end
  // Reset, then the scenarios in order
  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lim_ok, sw_ok, psi, cmd_motion} = {1'b1, 1'b1, 16'h0, 8'h00};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_limit();
    t_switch();
    t_sensor();
    t_valve();
    t_misc();
    end_sim();
  end
endmodule : csi_interlock_bench
